// ==== verilog/sync_receive_irq_crc.v ====
// synchronous-mode character receiver with receive interrupt modes and crc check
// assumes receive clock, data and carrier detect come from outside mclk's domain
//
// The register offsets and the strobed register port were chosen for this implementation.
`include "sync_rx_regs.vh"
`default_nettype none

// Function
// - after sync is found each assembled character goes into the receive fifo, except inhibited leading syncs and characters arriving while it is full
// - receive interrupt mode none raises no receive interrupt at all
// - first-character mode interrupts on the first character, then only on specials
// - the enable-on-next-character command re-arms first-character mode
// - first-character mode: parity no interrupt, overrun does
// - with external interrupts enabled a carrier detect change interrupts
// - every-character mode interrupts for each character entering the buffer
// - status-modifies-vector gives a distinct vector for special conditions
// - an option keeps parity errors out of the special vector
// - special interrupts only in first-character or every-character mode
// - receive overrun raises the special receive condition interrupt
// - overrun and parity flags are sticky until the error reset command
// - crc on a character starts eight bit times after its transfer
// - crc disabled at next transfer excludes the buffered character
// - crc error bit holds the checker result sixteen bit times after transfer
// - zero result means no error, valid only after calculation ends
// - comparison refreshed each transfer, valid while character sits in fifo
// - at a load the crc bit covers the character two positions earlier
// - auto-enable accepts data only while carrier detect is active
module sync_receive_irq_crc #(
    parameter DATA_BITS  = 8,
    parameter FIFO_DEPTH = 3
) (
    // clock and reset
    input  wire       mclk,
    input  wire       rstn,
    // register port
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    // serial line
    input  wire       receive_clock_pin,
    input  wire       rx_data,
    input  wire       carrier_detect_input,
    // host side
    output reg        int_req,
    output reg        rx_avail
);
    // ----------------------------------------------------------------
    // synchronisers and bit strobe
    // ----------------------------------------------------------------
    reg rxc_s1_r;
    reg rxc_s2_r;
    reg rxc_s3_r;
    reg rxd_s1_r;
    reg rxd_s2_r;
    reg dcd_s1_r;
    reg dcd_s2_r;
    reg dcd_s3_r;

    // two flops on every pin, a third stage for edge finding
    always @(posedge mclk) begin
        if (!rstn) begin
            rxc_s1_r <= 1'b0;
            rxc_s2_r <= 1'b0;
            rxc_s3_r <= 1'b0;
            rxd_s1_r <= 1'b0;
            rxd_s2_r <= 1'b0;
            dcd_s1_r <= 1'b0;
            dcd_s2_r <= 1'b0;
            dcd_s3_r <= 1'b0;
        end else begin
            rxc_s1_r <= receive_clock_pin;
            rxc_s2_r <= rxc_s1_r;
            rxc_s3_r <= rxc_s2_r;
            rxd_s1_r <= rx_data;
            rxd_s2_r <= rxd_s1_r;
            dcd_s1_r <= carrier_detect_input;
            dcd_s2_r <= dcd_s1_r;
            dcd_s3_r <= dcd_s2_r;
        end
    end

    wire bit_stb    = rxc_s2_r & ~rxc_s3_r;   // rising receive clock edge
    wire dcd_change = dcd_s2_r ^ dcd_s3_r;

    // ----------------------------------------------------------------
    // software registers and command decode
    // ----------------------------------------------------------------
    reg [7:0] setup_r;
    reg [7:0] irqcfg_r;
    reg [7:0] vec_r;
    reg [7:0] sync_r;

    wire       cmd_wr   = wr && (addr == `OFS_CMD);
    wire       cmd_err  = cmd_wr && (wdata[2:0] == `CMD_ERR_RST);
    wire       cmd_next = cmd_wr && (wdata[2:0] == `CMD_INT_NEXT);
    wire       cmd_ext  = cmd_wr && (wdata[2:0] == `CMD_EXT_RST);
    wire       cmd_crc  = cmd_wr && (wdata[2:0] == `CMD_CRC_RST);
    wire       cmd_ack  = cmd_wr && (wdata[2:0] == `CMD_RX_ACK);
    wire       hunt_wr  = wr && (addr == `OFS_RX_SETUP) && wdata[`SU_HUNT];
    wire [1:0] mode     = irqcfg_r[`IC_MODE_HI:`IC_MODE_LO];

    // configuration registers
    always @(posedge mclk) begin
        if (!rstn) begin
            setup_r  <= `SETUP_RST;
            irqcfg_r <= `IRQ_RST;
            vec_r    <= `VEC_RST;
            sync_r   <= `SYNC_RST;
        end else if (wr) begin
            case (addr)
                `OFS_RX_SETUP:  setup_r  <= wdata;
                `OFS_IRQ_CFG:   irqcfg_r <= wdata;
                `OFS_VECTOR:    vec_r    <= wdata;
                `OFS_SYNC_CHAR: sync_r   <= wdata;
                default:        ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // hunt and character assembly
    // ----------------------------------------------------------------
    reg        hunt_r;
    reg        lead_r;
    reg [7:0]  shift_r;
    reg [3:0]  bit_cnt_r;
    reg [7:0]  hold_r;
    reg        hold_v_r;
    reg [7:0]  crc_src_r;
    reg [3:0]  crc_cnt_r;

    wire       rx_active = setup_r[`SU_RX_EN] & (~setup_r[`SU_AUTO] | dcd_s2_r);
    wire       par_en    = setup_r[`SU_PAR_EN];
    wire [7:0] data_nxt  = {rxd_s2_r, shift_r[7:1]};
    wire [3:0] last_bit  = par_en ? DATA_BITS[3:0] : DATA_BITS[3:0] - 4'h1;
    wire       frame_end = bit_stb && rx_active && !hunt_r && (bit_cnt_r == last_bit);
    wire [7:0] char_val  = par_en ? shift_r : data_nxt;
    wire       par_err   = par_en & (^shift_r ^ rxd_s2_r ^ setup_r[`SU_PAR_ODD]);
    wire       is_lead   = lead_r && setup_r[`SU_SYNC_INH] && (char_val == sync_r);
    wire       xfer_try  = frame_end && !is_lead;

    wire       fifo_full;
    wire       fifo_empty;
    wire [9:0] fifo_head;
    wire       crc_nz;
    wire       ovr_evt   = xfer_try && fifo_full;
    wire       xfer_ok   = xfer_try && !fifo_full;
    wire       rd_data   = rd && (addr == `OFS_DATA) && !fifo_empty;

    // serial assembly, hunt for the sync character, leading-sync zone
    always @(posedge mclk) begin
        if (!rstn) begin
            hunt_r    <= 1'b1;
            lead_r    <= 1'b0;
            shift_r   <= 8'h00;
            bit_cnt_r <= 4'h0;
        end else if (hunt_wr) begin
            hunt_r    <= 1'b1;
            bit_cnt_r <= 4'h0;
        end else if (bit_stb && rx_active) begin
            if (hunt_r) begin
                shift_r <= data_nxt;
                if (data_nxt == sync_r) begin
                    hunt_r    <= 1'b0;
                    lead_r    <= 1'b1;
                    bit_cnt_r <= 4'h0;
                end
            end else begin
                if (bit_cnt_r < DATA_BITS[3:0])
                    shift_r <= data_nxt;
                if (frame_end) begin
                    bit_cnt_r <= 4'h0;
                    if (!is_lead)
                        lead_r <= 1'b0;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // crc pipeline: hold one character, shift it during the next one
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rstn || cmd_crc) begin
            hold_r    <= 8'h00;
            hold_v_r  <= 1'b0;
            crc_src_r <= 8'h00;
            crc_cnt_r <= 4'h0;
        end else if (xfer_ok) begin
            hold_r   <= char_val;
            hold_v_r <= 1'b1;
            if (hold_v_r) begin
                // enable is sampled at the next transfer
                crc_src_r <= hold_r;
                crc_cnt_r <= setup_r[`SU_CRC_EN] ? `CRC_SHIFT_BITS : 4'h0;
            end
        end else if (bit_stb && crc_cnt_r != 4'h0) begin
            crc_src_r <= {1'b0, crc_src_r[7:1]};
            crc_cnt_r <= crc_cnt_r - 4'h1;
        end
    end

    // checker, shifts the held character one bit per receive clock
    crc16_checker u_crc (
        .mclk     (mclk),
        .rstn     (rstn),
        .clear    (cmd_crc),
        .shift_en (bit_stb && crc_cnt_r != 4'h0),
        .bit_in   (crc_src_r[0]),
        .nonzero  (crc_nz)
    );

    // fifo entry: {crc result, parity error, character}
    rx_char_fifo #(
        .WIDTH (10),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .push      (xfer_ok),
        .push_data ({crc_nz, par_err, char_val}),
        .pop       (rd_data),
        .head      (fifo_head),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    // ----------------------------------------------------------------
    // error flags and interrupt sources
    // ----------------------------------------------------------------
    reg par_stk_r;
    reg ovr_stk_r;
    reg armed_r;
    reg rx_pend_r;
    reg spec_pend_r;
    reg ext_pend_r;

    wire rx_mode   = (mode != `MODE_NONE);
    wire every     = (mode == `MODE_EVERY_PAR) || (mode == `MODE_EVERY_NOP);
    wire par_spec  = (mode == `MODE_EVERY_PAR) && xfer_ok && par_err;
    wire spec_evt  = rx_mode && (ovr_evt || par_spec);
    wire first_evt = (mode == `MODE_FIRST) && armed_r && xfer_ok;
    wire rx_evt    = (every && xfer_ok) || first_evt;
    wire ext_evt   = irqcfg_r[`IC_EXT_EN] && dcd_change;

    // sticky error flags, a new error wins over the reset command
    always @(posedge mclk) begin
        if (!rstn) begin
            par_stk_r <= 1'b0;
            ovr_stk_r <= 1'b0;
        end else begin
            par_stk_r <= (xfer_ok && par_err) || (par_stk_r && !cmd_err);
            ovr_stk_r <= ovr_evt || (ovr_stk_r && !cmd_err);
        end
    end

    // pending bits, each set wins over its clear
    always @(posedge mclk) begin
        if (!rstn) begin
            armed_r     <= 1'b1;
            rx_pend_r   <= 1'b0;
            spec_pend_r <= 1'b0;
            ext_pend_r  <= 1'b0;
        end else begin
            if (cmd_next)
                armed_r <= 1'b1;
            else if (first_evt)
                armed_r <= 1'b0;
            rx_pend_r   <= rx_evt || (rx_pend_r && !cmd_ack && !rd_data);
            spec_pend_r <= spec_evt || (spec_pend_r && !cmd_err);
            ext_pend_r  <= ext_evt || (ext_pend_r && !cmd_ext);
        end
    end

    // vector code, special condition outranks receive and external
    wire [2:0] vcode = spec_pend_r ? `VEC_SPEC :
                       rx_pend_r   ? `VEC_RX   :
                       ext_pend_r  ? `VEC_EXT  : vec_r[3:1];
    wire [7:0] vec_out = irqcfg_r[`IC_SAV] ? {vec_r[7:4], vcode, vec_r[0]} : vec_r;

    // ----------------------------------------------------------------
    // read data and registered outputs
    // ----------------------------------------------------------------
    reg [7:0] rd_mux;
    reg [7:0] cond;
    reg [7:0] stat;

    // condition and status words
    always @* begin
        cond               = 8'h00;
        cond[`COND_PAR]    = par_stk_r | (!fifo_empty & fifo_head[8]);
        cond[`COND_OVR]    = ovr_stk_r;
        cond[`COND_CRC]    = !fifo_empty & fifo_head[9];
        stat               = 8'h00;
        stat[`ST_AVAIL]    = !fifo_empty;
        stat[`ST_INT]      = int_req;
        stat[`ST_DCD]      = dcd_s2_r;
        stat[`ST_HUNT]     = hunt_r;
    end

    // read multiplexer, unmapped addresses read zero
    always @* begin
        case (addr)
            `OFS_IRQ_CFG:   rd_mux = irqcfg_r;
            `OFS_VECTOR:    rd_mux = vec_r;
            `OFS_RX_SETUP:  rd_mux = setup_r;
            `OFS_SYNC_CHAR: rd_mux = sync_r;
            `OFS_DATA:      rd_mux = fifo_head[7:0];
            `OFS_STATUS:    rd_mux = stat;
            `OFS_COND:      rd_mux = cond;
            `OFS_VEC_RD:    rd_mux = vec_out;
            default:        rd_mux = 8'h00;
        endcase
    end

    // output flops
    always @(posedge mclk) begin
        if (!rstn) begin
            rdata    <= 8'h00;
            int_req  <= 1'b0;
            rx_avail <= 1'b0;
        end else begin
            rdata    <= rd ? rd_mux : 8'h00;
            int_req  <= rx_pend_r | spec_pend_r | ext_pend_r;
            rx_avail <= !fifo_empty && !rd_data;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/sync_rx_regs.vh ====
// register offsets, field positions, commands and reset values of the synchronous receiver
// assumes it is included by bare name from files compiled with `default_nettype none
`ifndef SYNC_RX_REGS_VH
`define SYNC_RX_REGS_VH

// ----------------------------------------------------------------
// register offsets (4-bit word address)
// ----------------------------------------------------------------
`define OFS_CMD        4'h0
`define OFS_IRQ_CFG    4'h1
`define OFS_VECTOR     4'h2
`define OFS_RX_SETUP   4'h3
`define OFS_SYNC_CHAR  4'h6
`define OFS_DATA       4'h8
`define OFS_STATUS     4'h9
`define OFS_COND       4'ha
`define OFS_VEC_RD     4'hb

// ----------------------------------------------------------------
// receiver_setup_register bits
// ----------------------------------------------------------------
`define SU_RX_EN       0
`define SU_PAR_EN      1
`define SU_PAR_ODD     2
`define SU_CRC_EN      3
`define SU_HUNT        4
`define SU_AUTO        5
`define SU_SYNC_INH    6

// ----------------------------------------------------------------
// interrupt configuration bits and receive interrupt modes
// ----------------------------------------------------------------
`define IC_EXT_EN      0
`define IC_SAV         2
`define IC_MODE_LO     3
`define IC_MODE_HI     4
`define MODE_NONE      2'h0
`define MODE_FIRST     2'h1
`define MODE_EVERY_PAR 2'h2
`define MODE_EVERY_NOP 2'h3

// ----------------------------------------------------------------
// commands (low three bits of a write to the command register)
// ----------------------------------------------------------------
`define CMD_EXT_RST    3'h2
`define CMD_INT_NEXT   3'h4
`define CMD_CRC_RST    3'h5
`define CMD_ERR_RST    3'h6
`define CMD_RX_ACK     3'h7

// ----------------------------------------------------------------
// status bits, condition status bits, vector codes
// ----------------------------------------------------------------
`define ST_AVAIL       0
`define ST_INT         1
`define ST_DCD         3
`define ST_HUNT        4
`define COND_PAR       4
`define COND_OVR       5
`define COND_CRC       6
`define VEC_EXT        3'h5
`define VEC_RX         3'h4
`define VEC_SPEC       3'h7

// ----------------------------------------------------------------
// reset values, crc and timing constants
// ----------------------------------------------------------------
`define SETUP_RST      8'h00
`define IRQ_RST        8'h00
`define VEC_RST        8'h00
`define SYNC_RST       8'h16
`define CRC_POLY       16'h8005
`define CRC_INIT       16'h0000
`define CRC_SHIFT_BITS 4'h8

`endif

// ==== verilog/rx_char_fifo.v ====
// receive character fifo held in flip-flops, head always visible
// assumes push is never given while full and pop never while empty
`include "sync_rx_regs.vh"
`default_nettype none

module rx_char_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 3
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rstn,
    // write side
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    // read side
    input  wire             pop,
    output wire [WIDTH-1:0] head,
    output wire             empty,
    output wire             full
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [1:0]       wr_r;
    reg [1:0]       rd_r;
    reg [1:0]       cnt_r;

    // pointer wrap used by both pointers
    function [1:0] wrap_inc;
        input [1:0] p;
        begin
            wrap_inc = (p == DEPTH - 1) ? 2'h0 : p + 2'h1;
        end
    endfunction

    assign head  = mem_r[rd_r];
    assign empty = (cnt_r == 2'h0);
    assign full  = (cnt_r == DEPTH);

    // storage and pointers
    always @(posedge mclk) begin
        if (!rstn) begin
            wr_r  <= 2'h0;
            rd_r  <= 2'h0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wr_r] <= push_data;
                wr_r        <= wrap_inc(wr_r);
            end
            if (pop)
                rd_r <= wrap_inc(rd_r);
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/crc16_checker.v ====
// serial crc-16 checker, one bit per shift enable
// assumes the whole message and its two crc characters are shifted in
`include "sync_rx_regs.vh"
`default_nettype none

module crc16_checker (
    // clock and reset
    input  wire mclk,
    input  wire rstn,
    // control
    input  wire clear,
    input  wire shift_en,
    input  wire bit_in,
    // result
    output wire nonzero
);
    reg  [15:0] crc_r;
    wire        fb      = bit_in ^ crc_r[15];
    wire [15:0] crc_nxt = {crc_r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);

    // a shift in this cycle is already counted, so a capture sees the final bit
    assign nonzero = shift_en ? |crc_nxt : |crc_r;

    // remainder register
    always @(posedge mclk) begin
        if (!rstn || clear)
            crc_r <= `CRC_INIT;
        else if (shift_en)
            crc_r <= crc_nxt;
    end
endmodule
`default_nettype wire

// ==== dv/sync_rx_checker.sv ====
// port-level checks of the synchronous receiver with interrupt modes
// assumes it is bound to sync_receive_irq_crc and sees only its ports
`include "sync_rx_regs.vh"
`default_nettype none

module sync_rx_checker (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rstn,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // serial line
    input wire logic       receive_clock_pin,
    input wire logic       rx_data,
    input wire logic       carrier_detect_input,
    // host side
    input wire logic       int_req,
    input wire logic       rx_avail
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] mode_r;
    logic       ext_r;
    logic       en_r;

    // ----------------------------------------
    // shadow of the settings software wrote
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_r <= `MODE_NONE;
            ext_r  <= 1'b0;
            en_r   <= 1'b0;
        end else if (wr && addr == `OFS_IRQ_CFG) begin
            mode_r <= wdata[`IC_MODE_HI:`IC_MODE_LO];
            ext_r  <= wdata[`IC_EXT_EN];
        end else if (wr && addr == `OFS_RX_SETUP) begin
            en_r <= wdata[`SU_RX_EN];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_reset_quiet: assert property ($past(!rstn) |-> rdata == 8'h00 && !int_req && !rx_avail)
        else $error("outputs not quiet after reset");
    chk_unmapped_zero: assert property (rd && addr == 4'hf |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_status_avail: assert property (rd && addr == `OFS_STATUS |=> rdata[`ST_AVAIL] == rx_avail)
        else $error("status avail bit disagrees with flag");
    chk_avail_drop: assert property ($fell(rx_avail) |-> $past(rd && addr == `OFS_DATA))
        else $error("avail fell without a data read");
    chk_avail_enable: assert property ($rose(rx_avail) |-> en_r)
        else $error("character stored while receiver off");
    chk_irq_mode_none: assert property ($rose(int_req) |-> mode_r != `MODE_NONE || ext_r)
        else $error("interrupt with all interrupts off");
    chk_irq_every: assert property (mode_r[1] && $rose(rx_avail) |-> ##[0:4] int_req)
        else $error("no interrupt for a stored character");
    chk_irq_carrier: assert property (ext_r && $changed(carrier_detect_input) |-> ##[1:10] int_req)
        else $error("no interrupt on carrier change");
    chk_irq_clear: assert property ($fell(int_req) |-> $past(wr || rd) || $past(wr || rd, 2))
        else $error("interrupt dropped without host access");
endmodule

bind sync_receive_irq_crc sync_rx_checker u_chk (
    .mclk                 (mclk),
    .rstn                 (rstn),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .receive_clock_pin    (receive_clock_pin),
    .rx_data              (rx_data),
    .carrier_detect_input (carrier_detect_input),
    .int_req              (int_req),
    .rx_avail             (rx_avail)
);
`default_nettype wire

// ==== dv/rx_line_model.sv ====
// remote synchronous transmitter driving clock and data of the line
// assumes the receiver samples data on the rising line clock
`default_nettype none

module rx_line_model (
    // serial line toward the receiver
    output logic lclk,
    output logic ldat
);
    timeunit 1ns;
    timeprecision 100ps;

    // line clock rests low, data idles high
    initial begin
        lclk = 1'b0;
        ldat = 1'b1;
    end

    // one frame lsb first; clock stands still between frames
    task automatic send(input logic [8:0] v, input int n);
        #37;
        for (int i = 0; i < n; i++) begin
            ldat = v[i];
            #100 lclk = 1'b1;
            #100 lclk = 1'b0;
        end
        ldat = ~ldat;  // released line shows no stale bit
    endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench of the synchronous receiver
// assumes the line model and the bound checker are compiled alongside
`include "sync_rx_regs.vh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       mclk;
    logic       rstn;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       lclk;
    logic       ldat;
    logic       carrier;
    logic       int_req;
    logic       rx_avail;
    int         num_errors;
    int         n_compared;

    sync_receive_irq_crc u_dut (
        .mclk                 (mclk),
        .rstn                 (rstn),
        .addr                 (addr),
        .wdata                (wdata),
        .wr                   (wr),
        .rd                   (rd),
        .rdata                (rdata),
        .receive_clock_pin    (lclk),
        .rx_data              (ldat),
        .carrier_detect_input (carrier),
        .int_req              (int_req),
        .rx_avail             (rx_avail)
    );

    rx_line_model u_line (
        .lclk (lclk),
        .ldat (ldat)
    );

    // 40 MHz system clock
    always #12.5 mclk = ~mclk;

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask

    task automatic cmd(input logic [2:0] c);
        wreg(`OFS_CMD, {5'h00, c});
    endtask

    task automatic rx(input logic [8:0] v, input int n);
        u_line.send(v, n);
        repeat (4) @(posedge mclk);
    endtask

    task automatic flags(input logic [1:0] e);
        repeat (6) @(negedge mclk);
        chk({6'h00, int_req, rx_avail}, {6'h00, e});
    endtask

    // four characters into a three deep fifo, then drain and clear
    task automatic burst(input logic [7:0] vexp, input logic [7:0] vm);
        for (int i = 1; i < 5; i++) rx({1'b0, i[7:0]}, 8);
        flags(2'b11);
        rreg(`OFS_VEC_RD, vexp, vm);
        rreg(`OFS_COND, 8'h20, 8'h20);
        for (int i = 1; i < 4; i++) rreg(`OFS_DATA, i[7:0], 8'hff);
        rreg(`OFS_COND, 8'h20, 8'h20);
        cmd(`CMD_ERR_RST);
        rreg(`OFS_COND, 8'h00, 8'h20);
        cmd(`CMD_RX_ACK);
        flags(2'b00);
    endtask

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        carrier = 1'b0;
        num_errors = 0;
        n_compared = 0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        rreg(`OFS_RX_SETUP, `SETUP_RST, 8'hff);
        rreg(`OFS_IRQ_CFG, `IRQ_RST, 8'hff);
        rreg(`OFS_SYNC_CHAR, `SYNC_RST, 8'hff);
        rreg(4'hf, 8'h00, 8'hff);
        flags(2'b00);
        $display("test reset done");
        wreg(`OFS_IRQ_CFG, 8'h08);
        wreg(`OFS_RX_SETUP, 8'h31);
        rx({1'b0, `SYNC_RST}, 8);
        rx(9'h05a, 8);
        flags(2'b00);
        rreg(`OFS_STATUS, 8'h10, 8'h10);
        carrier <= 1'b1;
        rx({1'b0, `SYNC_RST}, 8);
        rx(9'h0a5, 8);
        flags(2'b11);
        rreg(`OFS_DATA, 8'ha5, 8'hff);
        cmd(`CMD_RX_ACK);
        rx(9'h03c, 8);
        flags(2'b01);
        rreg(`OFS_DATA, 8'h3c, 8'hff);
        cmd(`CMD_INT_NEXT);
        rx(9'h0c3, 8);
        flags(2'b11);
        rreg(`OFS_DATA, 8'hc3, 8'hff);
        cmd(`CMD_RX_ACK);
        burst(8'h00, 8'hff);
        $display("test first character mode done");
        wreg(`OFS_IRQ_CFG, 8'h14);
        rx(9'h077, 8);
        flags(2'b11);
        rreg(`OFS_VEC_RD, 8'h08, 8'h0e);
        rreg(`OFS_DATA, 8'h77, 8'hff);
        cmd(`CMD_RX_ACK);
        burst(8'h0e, 8'h0e);
        $display("test every character mode done");
        wreg(`OFS_RX_SETUP, 8'h03);
        for (int m = 2; m < 4; m++) begin
            wreg(`OFS_IRQ_CFG, {3'h0, m[1:0], 3'h4});
            rx(9'h001, 9);
            flags(2'b11);
            rreg(`OFS_VEC_RD, (m == 2) ? 8'h0e : 8'h08, 8'h0e);
            rreg(`OFS_COND, 8'h10, 8'h10);
            rreg(`OFS_DATA, 8'h01, 8'hff);
            cmd(`CMD_ERR_RST);
            cmd(`CMD_RX_ACK);
            flags(2'b00);
        end
        $display("test parity done");
        wreg(`OFS_IRQ_CFG, 8'h01);
        cmd(`CMD_EXT_RST);
        rx(9'h003, 9);
        flags(2'b01);
        rreg(`OFS_DATA, 8'h03, 8'hff);
        carrier <= 1'b0;
        flags(2'b10);
        cmd(`CMD_EXT_RST);
        flags(2'b00);
        $display("test polled and carrier done");
        cmd(`CMD_CRC_RST);
        wreg(`OFS_RX_SETUP, 8'h19);
        rx({1'b0, `SYNC_RST}, 8);
        rx(9'h080, 8);
        rx(9'h000, 8);
        rx(9'h000, 8);
        for (int i = 0; i < 3; i++) begin
            rreg(`OFS_COND, (i == 2) ? 8'h40 : 8'h00, 8'h40);
            rreg(`OFS_DATA, (i == 0) ? 8'h80 : 8'h00, 8'hff);
        end
        $display("test crc done");
        wrap_up;
    end

    // cut a hang short well past the expected run time
    initial begin
        #500000;
        num_errors++;
        $display("watchdog expired");
        wrap_up;
    end
endmodule
`default_nettype wire
